// ==== hdl/mtcs_consts.vh ====
`ifndef MTCS_CONSTS_VH
`define MTCS_CONSTS_VH

// Register byte offsets on the host register port.
`define MTCS_OFS_CTRL      8'h70
`define MTCS_OFS_STAT      8'h72

// Transmit control fields.
`define MTCS_CTRL_ICMP     8
`define MTCS_CTRL_TCP      6
`define MTCS_CTRL_IP       5
`define MTCS_CTRL_FLUSH    4
`define MTCS_CTRL_FCE      3
`define MTCS_CTRL_PAD      2
`define MTCS_CTRL_CRC      1
`define MTCS_CTRL_RUN      0
`define MTCS_CTRL_WMASK    16'h017F
`define MTCS_CTRL_RESET    16'h0000

// Transmit status fields.
`define MTCS_STAT_LATE     13
`define MTCS_STAT_MAX      12
`define MTCS_STAT_FID_MSB  5
`define MTCS_STAT_RESET    16'h0000

// Frame lengths in bytes.
`define MTCS_MIN_NO_FCS    11'h03C
`define MTCS_MIN_WITH_FCS  11'h040
`define MTCS_PAUSE_LAST    11'h03B

// Frame parsing.
`define MTCS_ETYPE_IP      16'h0800
`define MTCS_ETYPE_CTRL    16'h8808
`define MTCS_PROTO_TCP     8'h06
`define MTCS_PROTO_ICMP    8'h01
`define MTCS_CRC_INIT      32'hFFFFFFFF
`define MTCS_CRC_POLY      32'hEDB88320

`endif

// ==== hdl/mtcs_fifo.v ====
`timescale 1ns/1ps
module mtcs_fifo #(
  parameter WIDTH = 15,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst_n,
  input  wire             flush,
  // Fill side
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output reg              in_ready_ff,
  // Drain side
  output wire [WIDTH-1:0] out_data,
  output reg              out_valid_ff,
  input  wire             out_ready
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_ff;
  reg [AW-1:0]    rd_ptr_ff;
  reg [AW:0]      count_ff;
  reg [AW:0]      nxt_count;
  wire            push;
  wire            pop;

  assign push     = in_valid & in_ready_ff & ~flush;
  assign pop      = out_ready & out_valid_ff & ~flush;
  assign out_data = mem[rd_ptr_ff];

  always @* begin
    nxt_count = count_ff;
    if (push & ~pop)
      nxt_count = count_ff + {{AW{1'b0}}, 1'b1};
    else if (pop & ~push)
      nxt_count = count_ff - {{AW{1'b0}}, 1'b1};
  end

  always @(posedge clk) begin
    if (push)
      mem[wr_ptr_ff] <= in_data;
  end

  // Flush returns both pointers to the start and empties the queue.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff    <= {AW{1'b0}};
      rd_ptr_ff    <= {AW{1'b0}};
      count_ff     <= {(AW+1){1'b0}};
      in_ready_ff  <= 1'b0;
      out_valid_ff <= 1'b0;
    end else if (flush) begin
      wr_ptr_ff    <= {AW{1'b0}};
      rd_ptr_ff    <= {AW{1'b0}};
      count_ff     <= {(AW+1){1'b0}};
      in_ready_ff  <= 1'b1;
      out_valid_ff <= 1'b0;
    end else begin
      if (push)
        wr_ptr_ff <= (wr_ptr_ff == DEPTH - 1) ? {AW{1'b0}} : wr_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
      if (pop)
        rd_ptr_ff <= (rd_ptr_ff == DEPTH - 1) ? {AW{1'b0}} : rd_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
      count_ff     <= nxt_count;
      in_ready_ff  <= (nxt_count != DEPTH);
      out_valid_ff <= (nxt_count != {(AW+1){1'b0}});
    end
  end

endmodule

// ==== hdl/mtcs_tx_ctrl.v ====
`timescale 1ns/1ps
`include "mtcs_consts.vh"
module mtcs_tx_ctrl #(
  parameter        FIFO_DEPTH  = 16,
  parameter        FIFO_AW     = 4,
  parameter [47:0] PAUSE_SA    = 48'h000000000000,
  parameter [15:0] PAUSE_QUANT = 16'hFFFF
) (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        resetn,
  // Host register port
  input  wire [7:0]  reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [1:0]  reg_be,
  input  wire [15:0] reg_wdata,
  output reg  [15:0] reg_rdata_ff,
  // Host frame data
  input  wire [7:0]  hd_data,
  input  wire [5:0]  hd_fid,
  input  wire        hd_last,
  input  wire        hd_valid,
  output wire        hd_ready,
  // Link transmit stream
  output reg  [7:0]  tx_data_ff,
  output reg         tx_valid_ff,
  output reg         tx_last_ff,
  input  wire        tx_ready,
  output reg         tx_ins_ip_ff,
  output reg         tx_ins_tcp_ff,
  output reg         tx_ins_icmp_ff,
  // Link status and flow control
  input  wire        full_duplex,
  input  wire        rx_over_thresh,
  input  wire        col_late,
  input  wire        col_max,
  output reg         backpressure_ff
);

  localparam S_IDLE  = 3'd0;
  localparam S_DATA  = 3'd1;
  localparam S_PAD   = 3'd2;
  localparam S_FCS   = 3'd3;
  localparam S_PAUSE = 3'd4;
  localparam [15:0] CTRL_WMASK = `MTCS_CTRL_WMASK;
  localparam [15:0] ETYPE_CTRL = `MTCS_ETYPE_CTRL;

  reg         rst_meta_ff;
  reg         rst_sync_ff;
  reg  [15:0] ctrl_ff;
  reg  [15:0] stat_ff;
  reg  [2:0]  state_ff;
  reg  [10:0] cnt_ff;
  reg  [31:0] crc_ff;
  reg  [1:0]  fcs_idx_ff;
  reg         pad_f_ff;
  reg         crc_f_ff;
  reg         is_pause_ff;
  reg  [5:0]  fid_ff;
  reg         late_ff;
  reg         max_ff;
  reg  [7:0]  etype_hi_ff;
  reg         is_ip_ff;
  reg         frag_ff;
  reg         is_tcp_ff;
  reg         is_icmp_ff;
  reg         thr_q_ff;
  reg         pause_pend_ff;
  wire [14:0] q_data;
  wire        q_valid;
  wire        q_ready;
  wire        adv;
  wire        run;
  wire        flush;
  wire        fce;
  wire [10:0] pad_len;
  wire [10:0] cnt_inc;
  wire        pause_trig;

  function [31:0] crc_byte;
    input [31:0] crc;
    input [7:0]  d;
    integer      i;
    reg   [31:0] c;
    begin
      c = crc;
      for (i = 0; i < 8; i = i + 1)
        c = (c[0] ^ d[i]) ? ((c >> 1) ^ `MTCS_CRC_POLY) : (c >> 1);
      crc_byte = c;
    end
  endfunction

  function [7:0] pause_byte;
    input [10:0] idx;
    begin
      case (idx)
        11'd0, 11'd5, 11'd15: pause_byte = 8'h01;
        11'd1:   pause_byte = 8'h80;
        11'd2:   pause_byte = 8'hC2;
        11'd6:   pause_byte = PAUSE_SA[47:40];
        11'd7:   pause_byte = PAUSE_SA[39:32];
        11'd8:   pause_byte = PAUSE_SA[31:24];
        11'd9:   pause_byte = PAUSE_SA[23:16];
        11'd10:  pause_byte = PAUSE_SA[15:8];
        11'd11:  pause_byte = PAUSE_SA[7:0];
        11'd12:  pause_byte = ETYPE_CTRL[15:8];
        11'd13:  pause_byte = ETYPE_CTRL[7:0];
        11'd16:  pause_byte = PAUSE_QUANT[15:8];
        11'd17:  pause_byte = PAUSE_QUANT[7:0];
        default: pause_byte = 8'h00;
      endcase
    end
  endfunction

  // Reset is released through two flops; everything else uses the copy.
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  assign run     = ctrl_ff[`MTCS_CTRL_RUN];
  assign flush   = ctrl_ff[`MTCS_CTRL_FLUSH];
  assign fce     = ctrl_ff[`MTCS_CTRL_FCE];
  assign adv     = ~tx_valid_ff | tx_ready;
  assign q_ready = adv & (state_ff == S_DATA);
  assign cnt_inc = cnt_ff + 11'd1;
  // Without an appended CRC the pad must reach the full 64 bytes itself.
  assign pad_len = crc_f_ff ? `MTCS_MIN_NO_FCS : `MTCS_MIN_WITH_FCS;
  assign pause_trig = fce & full_duplex & rx_over_thresh & ~thr_q_ff;

  mtcs_fifo #(
    .WIDTH (15),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk          (ref_clk),
    .rst_n        (rst_sync_ff),
    .flush        (flush),
    .in_data      ({hd_fid, hd_last, hd_data}),
    .in_valid     (hd_valid),
    .in_ready_ff  (hd_ready),
    .out_data     (q_data),
    .out_valid_ff (q_valid),
    .out_ready    (q_ready)
  );

  // Host register port: control and status registers.
  always @(posedge ref_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      ctrl_ff      <= `MTCS_CTRL_RESET;
      reg_rdata_ff <= 16'h0000;
    end else begin
      if (reg_wr && reg_addr == `MTCS_OFS_CTRL) begin
        if (reg_be[0])
          ctrl_ff[7:0] <= reg_wdata[7:0] & CTRL_WMASK[7:0];
        if (reg_be[1])
          ctrl_ff[15:8] <= reg_wdata[15:8] & CTRL_WMASK[15:8];
      end
      if (reg_rd) begin
        case (reg_addr)
          `MTCS_OFS_CTRL: reg_rdata_ff <= ctrl_ff;
          `MTCS_OFS_STAT: reg_rdata_ff <= stat_ff;
          default:        reg_rdata_ff <= 16'h0000;
        endcase
      end
    end
  end

  // Flow control: PAUSE in full duplex, back-pressure in half duplex.
  always @(posedge ref_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      thr_q_ff        <= 1'b0;
      pause_pend_ff   <= 1'b0;
      backpressure_ff <= 1'b0;
    end else begin
      thr_q_ff        <= rx_over_thresh;
      backpressure_ff <= fce & ~full_duplex & rx_over_thresh;
      if (pause_trig)
        pause_pend_ff <= 1'b1;
      else if (~fce | (state_ff == S_PAUSE))
        pause_pend_ff <= 1'b0;
    end
  end

  // Transmit engine. A stalled link holds the current byte in place.
  always @(posedge ref_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      state_ff       <= S_IDLE;
      cnt_ff         <= 11'd0;
      crc_ff         <= `MTCS_CRC_INIT;
      fcs_idx_ff     <= 2'd0;
      pad_f_ff       <= 1'b0;
      crc_f_ff       <= 1'b0;
      is_pause_ff    <= 1'b0;
      fid_ff         <= 6'd0;
      late_ff        <= 1'b0;
      max_ff         <= 1'b0;
      etype_hi_ff    <= 8'h00;
      is_ip_ff       <= 1'b0;
      frag_ff        <= 1'b0;
      is_tcp_ff      <= 1'b0;
      is_icmp_ff     <= 1'b0;
      stat_ff        <= `MTCS_STAT_RESET;
      tx_data_ff     <= 8'h00;
      tx_valid_ff    <= 1'b0;
      tx_last_ff     <= 1'b0;
      tx_ins_ip_ff   <= 1'b0;
      tx_ins_tcp_ff  <= 1'b0;
      tx_ins_icmp_ff <= 1'b0;
    end else begin
      if (state_ff != S_IDLE) begin
        if (col_late)
          late_ff <= 1'b1;
        if (col_max)
          max_ff <= 1'b1;
      end
      if (adv) begin
        tx_valid_ff    <= 1'b0;
        tx_last_ff     <= 1'b0;
        tx_ins_ip_ff   <= 1'b0;
        tx_ins_tcp_ff  <= 1'b0;
        tx_ins_icmp_ff <= 1'b0;
      end
      case (state_ff)
        S_IDLE: begin
          cnt_ff     <= 11'd0;
          crc_ff     <= `MTCS_CRC_INIT;
          fcs_idx_ff <= 2'd0;
          late_ff    <= 1'b0;
          max_ff     <= 1'b0;
          is_ip_ff   <= 1'b0;
          frag_ff    <= 1'b0;
          is_tcp_ff  <= 1'b0;
          is_icmp_ff <= 1'b0;
          // Run is only sampled between frames, so a stop never truncates.
          if (adv && !flush && pause_pend_ff) begin
            state_ff    <= S_PAUSE;
            is_pause_ff <= 1'b1;
            crc_f_ff    <= 1'b1;
          end else if (adv && !flush && run && q_valid) begin
            state_ff    <= S_DATA;
            is_pause_ff <= 1'b0;
            pad_f_ff    <= ctrl_ff[`MTCS_CTRL_PAD];
            crc_f_ff    <= ctrl_ff[`MTCS_CTRL_CRC];
            fid_ff      <= q_data[14:9];
          end
        end
        S_DATA: begin
          if (adv && q_valid) begin
            tx_data_ff  <= q_data[7:0];
            tx_valid_ff <= 1'b1;
            crc_ff      <= crc_byte(crc_ff, q_data[7:0]);
            cnt_ff      <= cnt_inc;
            if (cnt_ff == 11'd12)
              etype_hi_ff <= q_data[7:0];
            if (cnt_ff == 11'd13)
              is_ip_ff <= ({etype_hi_ff, q_data[7:0]} == `MTCS_ETYPE_IP);
            if (cnt_ff == 11'd20 && (q_data[5] || q_data[4:0] != 5'h00))
              frag_ff <= 1'b1;
            if (cnt_ff == 11'd21 && q_data[7:0] != 8'h00)
              frag_ff <= 1'b1;
            if (cnt_ff == 11'd23) begin
              is_tcp_ff  <= is_ip_ff & (q_data[7:0] == `MTCS_PROTO_TCP);
              is_icmp_ff <= is_ip_ff & (q_data[7:0] == `MTCS_PROTO_ICMP);
            end
            if (q_data[8]) begin
              if (pad_f_ff && cnt_inc < pad_len)
                state_ff <= S_PAD;
              else if (crc_f_ff)
                state_ff <= S_FCS;
              else begin
                state_ff   <= S_IDLE;
                tx_last_ff <= 1'b1;
              end
            end
          end
        end
        S_PAD: begin
          if (adv) begin
            tx_data_ff  <= 8'h00;
            tx_valid_ff <= 1'b1;
            crc_ff      <= crc_byte(crc_ff, 8'h00);
            cnt_ff      <= cnt_inc;
            if (cnt_inc == pad_len) begin
              if (crc_f_ff)
                state_ff <= S_FCS;
              else begin
                state_ff   <= S_IDLE;
                tx_last_ff <= 1'b1;
              end
            end
          end
        end
        S_PAUSE: begin
          if (adv) begin
            tx_data_ff  <= pause_byte(cnt_ff);
            tx_valid_ff <= 1'b1;
            crc_ff      <= crc_byte(crc_ff, pause_byte(cnt_ff));
            cnt_ff      <= cnt_inc;
            if (cnt_ff == `MTCS_PAUSE_LAST)
              state_ff <= S_FCS;
          end
        end
        S_FCS: begin
          if (adv) begin
            tx_data_ff  <= ~crc_ff[7:0];
            tx_valid_ff <= 1'b1;
            crc_ff      <= {8'h00, crc_ff[31:8]};
            fcs_idx_ff  <= fcs_idx_ff + 2'd1;
            if (fcs_idx_ff == 2'd3) begin
              state_ff   <= S_IDLE;
              tx_last_ff <= 1'b1;
            end
          end
        end
        default: state_ff <= S_IDLE;
      endcase
      // Status and offload requests are issued with the closing byte of a host frame; PAUSE frames leave them unchanged.
      if (adv && state_ff != S_IDLE && state_ff != S_PAUSE && !is_pause_ff) begin
        if ((state_ff == S_FCS && fcs_idx_ff == 2'd3) ||
            (state_ff == S_DATA && q_valid && q_data[8] && !crc_f_ff &&
             !(pad_f_ff && cnt_inc < pad_len)) ||
            (state_ff == S_PAD && cnt_inc == pad_len && !crc_f_ff)) begin
          stat_ff <= 16'h0000;
          stat_ff[`MTCS_STAT_LATE] <= late_ff | col_late;
          stat_ff[`MTCS_STAT_MAX]  <= max_ff | col_max;
          stat_ff[`MTCS_STAT_FID_MSB:0] <= fid_ff;
          tx_ins_ip_ff   <= ctrl_ff[`MTCS_CTRL_IP] & is_ip_ff;
          tx_ins_tcp_ff  <= ctrl_ff[`MTCS_CTRL_TCP] & is_tcp_ff;
          tx_ins_icmp_ff <= ctrl_ff[`MTCS_CTRL_ICMP] & is_icmp_ff & ~frag_ff;
        end
      end
    end
  end

endmodule

// ==== tb/mtcs_link_model.sv ====
`timescale 1ns/1ps
module mtcs_link_model (
  // Clock and pacing
  input  logic       ref_clk,
  input  logic       slow,
  // Stream from the block
  input  logic [7:0] tx_data_ff,
  input  logic       tx_valid_ff,
  input  logic       tx_last_ff,
  input  logic       tx_ins_ip_ff,
  input  logic       tx_ins_tcp_ff,
  input  logic       tx_ins_icmp_ff,
  output logic       tx_ready
);
  logic [7:0] rx_q[$];
  logic [2:0] ins_ff = 3'h0;
  int         frames = 0;
  initial tx_ready = 1'b1;
  // A slow link refuses about half the beats so the queue backs up.
  always @(posedge ref_clk) begin
    if (tx_valid_ff && tx_ready) begin
      rx_q.push_back(tx_data_ff);
      if (tx_last_ff) begin
        frames <= frames + 1;
        ins_ff <= {tx_ins_icmp_ff, tx_ins_tcp_ff, tx_ins_ip_ff};
      end
    end
    tx_ready <= slow ? 1'($urandom_range(1)) : 1'b1;
  end
endmodule

// ==== tb/mtcs_tx_ctrl_sva.sv ====
`timescale 1ns/1ps
module mtcs_tx_ctrl_sva (
  // Clock and reset
  input logic        ref_clk,
  input logic        resetn,
  // Register port
  input logic [7:0]  reg_addr,
  input logic        reg_rd,
  input logic [15:0] reg_rdata_ff,
  // Data and link
  input logic        hd_ready,
  input logic [7:0]  tx_data_ff,
  input logic        tx_valid_ff,
  input logic        tx_last_ff,
  input logic        tx_ready,
  input logic        tx_ins_tcp_ff,
  input logic        tx_ins_icmp_ff,
  input logic        full_duplex,
  input logic        rx_over_thresh,
  input logic        backpressure_ff
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  property p_rd_unmapped;
    reg_rd && reg_addr != 8'h70 && reg_addr != 8'h72 |=> reg_rdata_ff == 16'h0000;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped)
    else $error("unmapped read not zero");
  property p_ctrl_rsv;
    reg_rd && reg_addr == 8'h70 |=> reg_rdata_ff[15:9] == 7'h00 && !reg_rdata_ff[7];
  endproperty
  a_ctrl_rsv: assert property (p_ctrl_rsv)
    else $error("control reserved bits set");
  property p_stat_rsv;
    reg_rd && reg_addr == 8'h72 |=> reg_rdata_ff[15:14] == 2'h0 && reg_rdata_ff[11:6] == 6'h00;
  endproperty
  a_stat_rsv: assert property (p_stat_rsv)
    else $error("status reserved bits set");
  property p_rd_hold;
    !reg_rd |=> $stable(reg_rdata_ff);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data changed without read");
  property p_tx_hold;
    tx_valid_ff && !tx_ready |=> tx_valid_ff && $stable(tx_data_ff) && $stable(tx_last_ff);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("stalled link byte not held");
  property p_bp_half;
    backpressure_ff |-> $past(!full_duplex && rx_over_thresh);
  endproperty
  a_bp_half: assert property (p_bp_half)
    else $error("back-pressure without half duplex threshold");
  property p_bp_full;
    full_duplex [*2] |-> !backpressure_ff;
  endproperty
  a_bp_full: assert property (p_bp_full)
    else $error("back-pressure in full duplex");
  property p_csum_excl;
    tx_ins_tcp_ff |-> !tx_ins_icmp_ff;
  endproperty
  a_csum_excl: assert property (p_csum_excl)
    else $error("TCP and ICMP insertion together");
  property p_ready_rst;
    $rose(resetn) |-> !hd_ready ##1 !hd_ready;
  endproperty
  a_ready_rst: assert property (p_ready_rst)
    else $error("queue ready too early after reset");
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`include "mtcs_consts.vh"
module testbench;
  logic        ref_clk = 1'b0, resetn = 1'b0;
  logic [7:0]  reg_addr = 8'h00, hd_data = 8'h00;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, hd_last = 1'b0, hd_valid = 1'b0;
  logic [1:0]  reg_be = 2'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata_ff, ctrl = 16'h0000, stat = 16'h0000;
  logic [5:0]  hd_fid = 6'h00;
  logic        hd_ready, tx_valid_ff, tx_last_ff, tx_ready, backpressure_ff;
  logic [7:0]  tx_data_ff;
  logic        tx_ins_ip_ff, tx_ins_tcp_ff, tx_ins_icmp_ff, slow = 1'b0;
  logic        full_duplex = 1'b1, rx_over_thresh = 1'b0, col_late = 1'b0, col_max = 1'b0;
  int          failures = 0, checks_done = 0, cycles = 0, i, n, sd;

  mtcs_tx_ctrl u_mtcs_tx_ctrl (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_be(reg_be), .reg_wdata(reg_wdata),
    .reg_rdata_ff(reg_rdata_ff), .hd_data(hd_data), .hd_fid(hd_fid), .hd_last(hd_last),
    .hd_valid(hd_valid), .hd_ready(hd_ready), .tx_data_ff(tx_data_ff),
    .tx_valid_ff(tx_valid_ff), .tx_last_ff(tx_last_ff), .tx_ready(tx_ready),
    .tx_ins_ip_ff(tx_ins_ip_ff), .tx_ins_tcp_ff(tx_ins_tcp_ff),
    .tx_ins_icmp_ff(tx_ins_icmp_ff), .full_duplex(full_duplex),
    .rx_over_thresh(rx_over_thresh), .col_late(col_late), .col_max(col_max),
    .backpressure_ff(backpressure_ff));
  mtcs_link_model u_link (.ref_clk(ref_clk), .slow(slow), .tx_data_ff(tx_data_ff),
    .tx_valid_ff(tx_valid_ff), .tx_last_ff(tx_last_ff), .tx_ins_ip_ff(tx_ins_ip_ff),
    .tx_ins_tcp_ff(tx_ins_tcp_ff), .tx_ins_icmp_ff(tx_ins_icmp_ff), .tx_ready(tx_ready));

  always #20 ref_clk = ~ref_clk;

  task automatic stop_test;
    if (failures == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      stop_test();
    end
  end
  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t register got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_lnk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t link got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] crc_upd(input logic [31:0] c, input logic [7:0] d);
    c = c ^ {24'h000000, d};
    for (int b = 0; b < 8; b++)
      c = c[0] ? ((c >> 1) ^ `MTCS_CRC_POLY) : (c >> 1);
    return c;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
    reg_addr = a; reg_be = be; reg_wdata = d; reg_wr = 1'b1;
    @(posedge ref_clk); #1;
    reg_wr = 1'b0;
    // A quiet edge between accesses keeps each strobe to one change per time step.
    idle(1);
  endtask
  task automatic setc(input logic [15:0] d);
    wr(`MTCS_OFS_CTRL, 2'h3, d);
    ctrl = d;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    reg_addr = a; reg_rd = 1'b1;
    @(posedge ref_clk); #1;
    reg_rd = 1'b0;
    chk_reg(reg_rdata_ff, exp);
    idle(1);
  endtask
  task automatic push(input logic [7:0] d, input logic l);
    hd_data = d; hd_last = l; hd_valid = 1'b1;
    while (hd_ready !== 1'b1) begin
      @(posedge ref_clk); #1;
    end
    @(posedge ref_clk); #1;
  endtask
  task automatic wait_frame(input int f);
    for (int w = 0; w < 3000 && u_link.frames == f; w++)
      @(posedge ref_clk);
    #1;
    if (u_link.frames == f) begin
      failures++;
      $display("[ERR] %0t frame never completed", $time);
    end
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask
  task automatic send(input int len, input logic [7:0] et, input logic [7:0] pr,
                      input logic [7:0] fr, input bit stop);
    logic [7:0] f[$];
    logic [31:0] c;
    logic lc, mc, pad, crc, ip;
    int k, el, t;
    for (k = 0; k < len; k++) f.push_back(8'($urandom));
    f[12] = 8'h08; f[13] = et; f[20] = fr; f[21] = 8'h00; f[23] = pr;
    lc = 1'($urandom); mc = 1'($urandom); pad = ctrl[2]; crc = ctrl[1]; ip = et == 8'h00;
    hd_fid = 6'($urandom);
    n = u_link.frames;
    u_link.rx_q.delete();
    for (k = 0; k < len; k++) begin
      if (stop && k == 8) begin
        hd_valid = 1'b0;
        setc(ctrl & 16'hFFFE);
      end
      col_late = (k == 6) & lc; col_max = (k == 6) & mc;
      push(f[k], k == len - 1);
    end
    hd_valid = 1'b0; hd_last = 1'b0; col_late = 1'b0; col_max = 1'b0;
    wait_frame(n);
    t = crc ? 60 : 64;
    el = (pad && len < t) ? t : len;
    chk_lnk(8'(u_link.rx_q.size()), 8'(el + (crc ? 4 : 0)));
    c = `MTCS_CRC_INIT;
    for (k = 0; k < el; k++) begin
      chk_lnk(u_link.rx_q[k], k < len ? f[k] : 8'h00);
      c = crc_upd(c, k < len ? f[k] : 8'h00);
    end
    for (k = 0; k < 4 && crc; k++) chk_lnk(u_link.rx_q[el + k], 8'(~c >> (8 * k)));
    chk_lnk({5'h00, u_link.ins_ff}, {5'h00, ctrl[8] & ip & pr == 8'h01 & fr == 8'h00,
             ctrl[6] & ip & pr == 8'h06, ctrl[5] & ip});
    stat = {2'h0, lc, mc, 6'h00, hd_fid};
    rd(`MTCS_OFS_STAT, stat);
  endtask

  initial begin
    sd = $urandom(32'hD31596AA);
    idle(8);
    resetn = 1'b1;
    idle(4);
    rd(`MTCS_OFS_CTRL, 16'h0000);
    rd(`MTCS_OFS_STAT, 16'h0000);
    wr(`MTCS_OFS_STAT, 2'h3, 16'hFFFF);
    rd(`MTCS_OFS_STAT, 16'h0000);
    rd(8'h74, 16'h0000);
    wr(`MTCS_OFS_CTRL, 2'h3, 16'hFFEE);
    rd(`MTCS_OFS_CTRL, 16'h016E);
    wr(`MTCS_OFS_CTRL, 2'h1, 16'h0000);
    rd(`MTCS_OFS_CTRL, 16'h0100);
    for (i = 0; i < 8; i++) begin
      slow = i[0];
      // Padding is only ever enabled together with FCS append.
      setc({7'h00, i == 7 | 1'($urandom), 1'b0, 2'($urandom), 2'h0,
            i == 0, i == 0 | 1'($urandom), 1'b1});
      send(i == 0 ? 24 : i == 1 ? 60 : $urandom_range(24, 90), i == 6 ? 8'h06 : 8'h00,
           i % 3 == 0 ? 8'h06 : i % 3 == 1 ? 8'h01 : 8'h11,
           i == 1 ? 8'h20 : i == 4 ? 8'h01 : 8'h00, i == 3);
    end
    setc(16'h0006);
    n = u_link.frames;
    for (i = 0; i < 16; i++) push(8'(i), i == 15);
    hd_valid = 1'b0;
    idle(30);
    chk_lnk({7'h00, hd_ready}, 8'h00);
    chk_lnk(8'(u_link.frames - n), 8'h00);
    // Run is cleared before flush is raised, and flush is dropped before run returns.
    setc(16'h0016);
    idle(4);
    setc(16'h0006);
    setc(16'h0007);
    idle(40);
    chk_lnk(8'(u_link.frames - n), 8'h00);
    chk_lnk({7'h00, hd_ready}, 8'h01);
    setc(16'h000B);
    u_link.rx_q.delete();
    rx_over_thresh = 1'b1;
    wait_frame(n);
    chk_lnk(8'(u_link.rx_q.size()), 8'h40);
    chk_lnk(u_link.rx_q[0], 8'h01);
    chk_lnk(u_link.rx_q[12], 8'h88);
    chk_lnk(u_link.rx_q[15], 8'h01);
    chk_lnk({7'h00, backpressure_ff}, 8'h00);
    rd(`MTCS_OFS_STAT, stat);
    full_duplex = 1'b0;
    idle(2);
    chk_lnk({7'h00, backpressure_ff}, 8'h01);
    setc(16'h0003);
    idle(2);
    chk_lnk({7'h00, backpressure_ff}, 8'h00);
    full_duplex = 1'b1; rx_over_thresh = 1'b0;
    n = u_link.frames;
    idle(2);
    rx_over_thresh = 1'b1;
    idle(100);
    chk_lnk(8'(u_link.frames - n), 8'h00);
    stop_test();
  end
endmodule

bind mtcs_tx_ctrl mtcs_tx_ctrl_sva u_sva (.ref_clk(ref_clk), .resetn(resetn),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .hd_ready(hd_ready),
  .tx_data_ff(tx_data_ff), .tx_valid_ff(tx_valid_ff), .tx_last_ff(tx_last_ff),
  .tx_ready(tx_ready), .tx_ins_tcp_ff(tx_ins_tcp_ff), .tx_ins_icmp_ff(tx_ins_icmp_ff),
  .full_duplex(full_duplex), .rx_over_thresh(rx_over_thresh),
  .backpressure_ff(backpressure_ff));
